//--- design/tpsd_pkg.sv
/*
 * Shared constants for the three-phase sine duty generator: phase,
 * index and sample widths, phase offsets, quarter-wave sine samples,
 * reset values and clock timing.
 * Assumes nothing of its surroundings; it is imported by every design file.
 */
package tpsd_pkg;

	// =====================================================================
	// widths
	// =====================================================================
	localparam int PHASE_W     = 16;
	localparam int SAMPLE_W    = 16;
	localparam int INDEX_W     = 6;
	localparam int TABLE_DEPTH = 64;
	localparam int QUARTER     = 16;
	localparam int INDEX_SHIFT = PHASE_W - INDEX_W;
	localparam int FRAC_SHIFT  = 15;
	localparam int NUM_PHASES  = 3;

	// =====================================================================
	// phase offsets, modulo 2^16
	// =====================================================================
	localparam logic [PHASE_W-1:0] OFFSET_A = 16'h0000;
	localparam logic [PHASE_W-1:0] OFFSET_B = 16'h5555;
	localparam logic [PHASE_W-1:0] OFFSET_C = 16'haaaa;
	localparam logic [PHASE_W-1:0] PHASE_OFFSET [0:NUM_PHASES-1] =
		'{OFFSET_A, OFFSET_B, OFFSET_C};

	// =====================================================================
	// reset values
	// =====================================================================
	localparam logic [PHASE_W-1:0]  ACC_RESET    = 16'h0000;
	localparam logic [PHASE_W-1:0]  DUTY_RESET   = 16'h0000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 16'h0000;

	// =====================================================================
	// timing: 20 MHz clock, period events every 50 us in the example
	// =====================================================================
	localparam int CLOCK_NS      = 50;
	localparam int EVENT_US      = 50;
	localparam int EVENT_CYCLES  = EVENT_US * 1000 / CLOCK_NS;
	localparam int PHASE_SCALE   = 65536;

	// =====================================================================
	// first quarter of the sine wave, q15 fractions, 0 to 90 degrees
	// =====================================================================
	localparam logic [SAMPLE_W-1:0] SINE_QUARTER [0:QUARTER] = '{
		16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56, 16'h471c,
		16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2, 16'h7641, 16'h7a7c,
		16'h7d89, 16'h7f61, 16'h7fff};

	// phase increment for a wanted sine frequency, rounded to nearest
	function automatic logic [PHASE_W-1:0] tpsd_phase_increment(
		input int unsigned freq_hz,
		input int unsigned switching_frequency);
		longint unsigned num;
		num = longint'(PHASE_SCALE) * freq_hz + switching_frequency / 2;
		return PHASE_W'(num / switching_frequency);
	endfunction

	typedef enum logic [1:0] {
		TPSD_IDLE,
		TPSD_FETCH,
		TPSD_SCALE,
		TPSD_WRITE
	} tpsd_state_t;

endpackage

//--- design/tpsd_lookup_if.sv
/*
 * Carrier between the sequencer and the sine table: an index going out
 * and the registered sample coming back one clock later.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface tpsd_lookup_if;
	import tpsd_pkg::*;

	logic [INDEX_W-1:0]         index;
	logic signed [SAMPLE_W-1:0] sample;

	modport user  (output index, input sample);
	modport table_end (input index, output sample);
endinterface

//--- design/tpsd_sine_table.sv
/*
 * Sixty-four word signed sine table, one full electrical cycle, built
 * from the quarter wave by symmetry; registered read.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module tpsd_sine_table
	import tpsd_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         reset,
	tpsd_lookup_if.table_end  lookup
);

	// =====================================================================
	// table contents
	// =====================================================================
	logic [SAMPLE_W-1:0] table_word [0:TABLE_DEPTH-1];

	for (genvar k = 0; k < TABLE_DEPTH; k++) begin : g_entry
		if (k <= QUARTER) begin : g_q0
			assign table_word[k] = SINE_QUARTER[k];
		end else if (k <= 2 * QUARTER) begin : g_q1
			assign table_word[k] = SINE_QUARTER[2 * QUARTER - k];
		end else if (k <= 3 * QUARTER) begin : g_q2
			assign table_word[k] = SAMPLE_W'(-$signed(SINE_QUARTER[k - 2 * QUARTER]));
		end else begin : g_q3
			assign table_word[k] = SAMPLE_W'(-$signed(SINE_QUARTER[4 * QUARTER - k]));
		end
	end

	// =====================================================================
	// registered read
	// =====================================================================
	logic [SAMPLE_W-1:0] next_sample;
	logic [SAMPLE_W-1:0] sample;

	always_comb begin
		next_sample = table_word[lookup.index];
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sample <= SAMPLE_RESET;
		end else begin
			sample <= next_sample;
		end
	end

	assign lookup.sample = $signed(sample);

endmodule // tpsd_sine_table

//--- design/tpsd_top.sv
/*
 * Three-phase sine duty generator. On each PWM period event taken while idle it advances
 * a phase accumulator, looks up three sine samples 120 degrees apart,
 * scales and offsets them by the period value and presents three duty
 * words together with a one-cycle write strobe.
 * Assumes the period event is a one-cycle pulse on the same clock, that
 * pwm_period_value stays below 16'h8000 and holds steady while busy.
 */
// How it works
// - one electrical cycle of sine data sits in a 64-word table.
// - table entries are signed q15 fractions from minus one to plus one.
// - 16-bit unsigned phase; zero is 0 degrees, all ones just under 360.
// - each period event taken while idle adds the increment before any duty is computed.
// - increment is 2^16 times sine frequency over switching frequency, rounded.
// - phases B and C point at accumulator plus 0x5555 and 0xaaaa.
// - each pointer shifted right by ten leaves a six-bit index.
// - the six-bit index selects the sample from the table.
// - sample times period value, as a signed fraction, gives amplitude.
// - period value added to amplitude makes every duty word non-negative.
// - duty spans zero to twice the period; mid-scale equals the period.
// - same computation for all three phases, each to its own word.
// - table contents may be pre-scaled to save multiply work.
`timescale 1ns/1ns
module tpsd_top
	import tpsd_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic                period_event,
	input  wire logic [PHASE_W-1:0]  pwm_period_value,
	input  wire logic [PHASE_W-1:0]  phase_increment,
	output logic      [PHASE_W-1:0]  duty_word_a,
	output logic      [PHASE_W-1:0]  duty_word_b,
	output logic      [PHASE_W-1:0]  duty_word_c,
	output logic                     duty_write,
	output logic      [PHASE_W-1:0]  phase_accumulator,
	output logic                     busy,
	output logic                     overrun
);

	// =====================================================================
	// sine table
	// =====================================================================
	tpsd_lookup_if lookup ();

	tpsd_sine_table u_table (
		.clock  (clock),
		.reset  (reset),
		.lookup (lookup.table_end)
	);

	// =====================================================================
	// state
	// =====================================================================
	tpsd_state_t         state;
	tpsd_state_t         next_state;
	logic [1:0]          phase_sel;
	logic [1:0]          next_phase_sel;
	logic [PHASE_W-1:0]  acc;
	logic [PHASE_W-1:0]  next_acc;
	logic [PHASE_W-1:0]  staged [0:NUM_PHASES-1];
	logic [PHASE_W-1:0]  next_staged [0:NUM_PHASES-1];
	logic [PHASE_W-1:0]  duty [0:NUM_PHASES-1];
	logic [PHASE_W-1:0]  next_duty [0:NUM_PHASES-1];
	logic                strobe;
	logic                next_strobe;
	logic                miss;
	logic                next_miss;

	// =====================================================================
	// pointer, index and scaling datapath
	// =====================================================================
	logic [PHASE_W-1:0]         pointer;
	logic signed [32:0]         product;
	logic signed [SAMPLE_W-1:0] amplitude;
	logic [PHASE_W-1:0]         scaled;

	always_comb begin
		pointer      = acc + PHASE_OFFSET[phase_sel];
		lookup.index = INDEX_W'(pointer >> INDEX_SHIFT);
	end

	always_comb begin
		product   = lookup.sample * $signed({1'b0, pwm_period_value});
		amplitude = SAMPLE_W'(product >>> FRAC_SHIFT);
		scaled    = PHASE_W'($signed({1'b0, pwm_period_value}) + amplitude);
	end

	// =====================================================================
	// sequencer
	// =====================================================================
	always_comb begin
		next_state     = state;
		next_phase_sel = phase_sel;
		next_acc       = acc;
		next_staged    = staged;
		next_duty      = duty;
		next_strobe    = 1'b0;
		next_miss      = 1'b0;
		unique case (state)
			TPSD_IDLE: begin
				if (period_event) begin
					next_acc       = acc + phase_increment;
					next_phase_sel = 2'd0;
					next_state     = TPSD_FETCH;
				end
			end
			TPSD_FETCH: begin
				next_state = TPSD_SCALE;
			end
			TPSD_SCALE: begin
				next_staged[phase_sel] = scaled;
				if (phase_sel == 2'(NUM_PHASES - 1)) begin
					next_state = TPSD_WRITE;
				end else begin
					next_phase_sel = phase_sel + 2'd1;
					next_state     = TPSD_FETCH;
				end
			end
			TPSD_WRITE: begin
				next_duty   = staged;
				next_strobe = 1'b1;
				next_state  = TPSD_IDLE;
			end
		endcase
		if (period_event && state != TPSD_IDLE) begin
			next_miss = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state     <= TPSD_IDLE;
			phase_sel <= 2'd0;
			acc       <= ACC_RESET;
			staged    <= '{default: DUTY_RESET};
			duty      <= '{default: DUTY_RESET};
			strobe    <= 1'b0;
			miss      <= 1'b0;
		end else begin
			state     <= next_state;
			phase_sel <= next_phase_sel;
			acc       <= next_acc;
			staged    <= next_staged;
			duty      <= next_duty;
			strobe    <= next_strobe;
			miss      <= next_miss;
		end
	end

	// =====================================================================
	// outputs
	// =====================================================================
	assign duty_word_a       = duty[0];
	assign duty_word_b       = duty[1];
	assign duty_word_c       = duty[2];
	assign duty_write        = strobe;
	assign phase_accumulator = acc;
	assign busy              = (state != TPSD_IDLE);
	assign overrun           = miss;

endmodule // tpsd_top

//--- verif/tpsd_props.sv
/* port checker for the sine duty generator
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/1ns
module tpsd_props
	import tpsd_pkg::*;
(
	input wire logic               clock,
	input wire logic               reset,
	input wire logic               period_event,
	input wire logic [PHASE_W-1:0] pwm_period_value,
	input wire logic [PHASE_W-1:0] phase_increment,
	input wire logic [PHASE_W-1:0] duty_word_a,
	input wire logic [PHASE_W-1:0] duty_word_b,
	input wire logic [PHASE_W-1:0] duty_word_c,
	input wire logic               duty_write,
	input wire logic [PHASE_W-1:0] phase_accumulator,
	input wire logic               busy,
	input wire logic               overrun
);
	// ==========
	// properties
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire take = period_event && !busy;
	AST_ACC_STEP: assert property (take |=> phase_accumulator ==
		$past(phase_accumulator) + $past(phase_increment)) else $error("acc step");
	AST_ACC_HOLD: assert property (!take |=> $stable(phase_accumulator))
		else $error("acc moved");
	AST_WRITE_LAT: assert property (take |-> ##8 duty_write) else $error("late");
	AST_BUSY_RUN: assert property (take |=> busy[*7] ##1 !busy) else $error("busy");
	AST_WRITE_PULSE: assert property (duty_write |=> !duty_write) else $error("pulse");
	AST_WORD_HOLD: assert property (!duty_write && !$past(reset) |->
		$stable({duty_word_a, duty_word_b, duty_word_c})) else $error("word moved");
	AST_RANGE: assert property (duty_write |-> duty_word_a <= {pwm_period_value, 1'b0} &&
		duty_word_b <= {pwm_period_value, 1'b0} && duty_word_c <= {pwm_period_value, 1'b0})
		else $error("range");
	AST_OVR: assert property (period_event && busy |=> overrun)
		else $error("no overrun");
	AST_OVR_CAUSE: assert property (overrun |-> $past(period_event && busy))
		else $error("ovr");
	cover property (duty_write);
	cover property (overrun);
	cover property ($past(phase_accumulator) > phase_accumulator);
endmodule // tpsd_props

bind tpsd_top tpsd_props u_props (.clock(clock), .reset(reset), .period_event(period_event),
	.pwm_period_value(pwm_period_value), .phase_increment(phase_increment),
	.duty_word_a(duty_word_a), .duty_word_b(duty_word_b), .duty_word_c(duty_word_c),
	.duty_write(duty_write), .phase_accumulator(phase_accumulator), .busy(busy),
	.overrun(overrun));

//--- verif/tpsd_pwm_model.sv
/* far-side pwm generator: periodic period event, latched phase A duty
   assumes the generator's clock and reset */
`timescale 1ns/1ns
module tpsd_pwm_model #(
	parameter int SPACING = 20
)(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        enable,
	input  wire logic        duty_write,
	input  wire logic [15:0] duty_word_a,
	output logic             period_event,
	output logic      [15:0] held_a
);
	int count;
	always_ff @(posedge clock) begin
		if (reset || !enable) begin
			count <= 0;
			period_event <= 1'b0;
		end else begin
			period_event <= (count == SPACING - 1);
			count <= (count == SPACING - 1) ? 0 : count + 1;
		end
		if (reset)
			held_a <= 16'h0000;
		else if (duty_write)
			held_a <= duty_word_a;
	end
endmodule // tpsd_pwm_model

//--- verif/three_phase_sine_duty_gen_test.sv
/* self-checking bench for the sine duty generator
   assumes the design and the far-side model compiled before it */
`timescale 1ns/1ns
module three_phase_sine_duty_gen_test;
	import tpsd_pkg::*;
	logic        clock = 0, reset = 1, tb_ev = 0, enable = 0, dw, busy, ovr, m_ev;
	logic [15:0] p = 16'h0000, inc = 16'h0000, exp_acc = 16'h0000, a, b, c, acc, held_a;
	logic [15:0] row_p [4] = '{16'h01f3, 16'h7fff, 16'h0000, 16'h0100};
	logic [15:0] row_inc [4] = '{16'h00c5, 16'h0400, 16'h4000, 16'hfc00};
	logic [15:0] row_acc [4] = '{16'h00c5, 16'h04c5, 16'h44c5, 16'h40c5};
	int          bad_count = 0, n_checks = 0;
	tpsd_top dut (.clock(clock), .reset(reset), .period_event(m_ev | tb_ev),
		.pwm_period_value(p), .phase_increment(inc), .duty_word_a(a), .duty_word_b(b),
		.duty_word_c(c), .duty_write(dw), .phase_accumulator(acc), .busy(busy), .overrun(ovr));
	tpsd_pwm_model model (.clock(clock), .reset(reset), .enable(enable), .duty_write(dw),
		.duty_word_a(a), .period_event(m_ev), .held_a(held_a));
	initial forever #25 clock = ~clock;
	// ==========
	// helpers
	function automatic logic [15:0] exp_duty(input logic [15:0] ptr, pv);
		logic [5:0] i;
		logic signed [16:0] s;
		logic signed [33:0] m;
		i = ptr[15:10];
		if (i <= 16) s = {1'b0, SINE_QUARTER[i]};
		else if (i <= 32) s = {1'b0, SINE_QUARTER[32 - i]};
		else if (i <= 48) s = -{1'b0, SINE_QUARTER[i - 32]};
		else s = -{1'b0, SINE_QUARTER[64 - i]};
		m = s * $signed({1'b0, pv});
		return pv + m[30:15];
	endfunction
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t word %h not %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic wait_write;
		@(negedge clock);
		for (int i = 0; i < 40 && dw !== 1'b1; i++) @(negedge clock);
		cmp_flag(dw, 1'b1);
	endtask
	task automatic check_all(input logic [15:0] pv);
		cmp_word(acc, exp_acc);
		cmp_word(a, exp_duty(exp_acc, pv));
		cmp_word(b, exp_duty(exp_acc + 16'h5555, pv));
		cmp_word(c, exp_duty(exp_acc + 16'haaaa, pv));
	endtask
	task automatic pulse;
		tb_ev <= 1'b1;
		@(posedge clock);
		tb_ev <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		cmp_word({a | b | c} | acc, 16'h0000);
		cmp_word(tpsd_phase_increment(60, 20000), 16'h00c5);
		$display("test reset values done");
		@(posedge clock);
		p <= row_p[0];
		inc <= row_inc[0];
		enable <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			wait_write();
			exp_acc = row_acc[r];
			check_all(row_p[r]);
			@(posedge clock);
			if (r < 3) begin
				p <= row_p[r + 1];
				inc <= row_inc[r + 1];
			end else
				enable <= 1'b0;
			$display("test row %0d done", r);
		end
		@(negedge clock);
		cmp_word(held_a, exp_duty(exp_acc, p));
		@(posedge clock);
		pulse();
		@(posedge clock);
		pulse();
		@(negedge clock);
		cmp_flag(ovr, 1'b1);
		cmp_flag(busy, 1'b1);
		wait_write();
		exp_acc = exp_acc + inc;
		check_all(p);
		$display("test overrun done");
		@(posedge clock);
		pulse();
		repeat (3) @(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		cmp_word(acc | a | b | c, 16'h0000);
		cmp_flag(busy | dw, 1'b0);
		@(posedge clock);
		pulse();
		exp_acc = inc;
		wait_write();
		check_all(p);
		$display("test mid reset done");
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		$display("CHECK FAILED %0t watchdog", $time);
		wrap_up();
	end
endmodule // three_phase_sine_duty_gen_test
